// >>> core/c2fs_cfg.svh
`ifndef C2FS_CFG_SVH
`define C2FS_CFG_SVH

// Field widths
`define C2FS_CREDIT_W 16
`define C2FS_LEN_W 12
`define C2FS_RETRY_W 4
`define C2FS_ID_W 24
`define C2FS_XID_W 16
`define C2FS_SEQID_W 8
`define C2FS_CNT_W 16
`define C2FS_RSN_W 8

// Reset values
`define C2FS_CREDIT_RST 16'h0000
`define C2FS_CNT_RST 16'h0000
`define C2FS_RETRY_RST 4'h0

// Reason codes placed in ack, port busy and reject answers
`define C2FS_RSN_NONE 8'h00
`define C2FS_RSN_BUSY 8'h01
`define C2FS_RSN_NOLOGIN 8'h03
`define C2FS_RSN_DELIM 8'h05

`endif

// >>> core/c2fs_credit.sv
`timescale 1ns/1ps
`default_nettype none
`include "c2fs_cfg.svh"

module c2fs_credit
    import c2fs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [`C2FS_CREDIT_W-1:0] init_i,
    input wire logic take_i,
    input wire logic give_i,
    output logic avail_o
);

    logic [`C2FS_CREDIT_W-1:0] cnt_r;
    logic [`C2FS_CREDIT_W-1:0] cnt_nxt;
    wire logic at_max = &cnt_r;

    assign avail_o = |cnt_r;

    // Give is held at the top so a stray return cannot wrap to zero
    always_comb begin
        cnt_nxt = cnt_r;
        if (load_i) begin
            cnt_nxt = init_i;
        end else if (take_i && !give_i) begin
            cnt_nxt = cnt_r - `C2FS_CREDIT_W'(1);
        end else if (give_i && !take_i && !at_max) begin
            cnt_nxt = cnt_r + `C2FS_CREDIT_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= `C2FS_CREDIT_RST;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule : c2fs_credit

`default_nettype wire

// >>> core/c2fs_pkg.sv
`include "c2fs_cfg.svh"

package c2fs_pkg;

    typedef enum logic [2:0] {
        C2FS_SOF_I2 = 3'h0,
        C2FS_SOF_N2 = 3'h1,
        C2FS_SOF_I3 = 3'h2,
        C2FS_SOF_N3 = 3'h3,
        C2FS_SOF_BAD = 3'h7
    } c2fs_sof_t;

    typedef enum logic [1:0] {
        C2FS_EOF_N = 2'h0,
        C2FS_EOF_T = 2'h1,
        C2FS_EOF_BAD = 2'h3
    } c2fs_eof_t;

    typedef enum logic [2:0] {
        C2FS_K_DATA = 3'h0,
        C2FS_K_NOP = 3'h1,
        C2FS_K_ACK = 3'h2,
        C2FS_K_PBSY = 3'h3,
        C2FS_K_FBSY = 3'h4,
        C2FS_K_PRJT = 3'h5,
        C2FS_K_FRJT = 3'h6
    } c2fs_kind_t;

    typedef enum logic [1:0] {
        C2FS_S_IDLE = 2'b00,
        C2FS_S_PUSH = 2'b01,
        C2FS_S_WAIT = 2'b10
    } c2fs_state_t;

    typedef struct packed {
        c2fs_kind_t kind;
        c2fs_sof_t sof;
        c2fs_eof_t eof;
        logic [`C2FS_ID_W-1:0] d_id;
        logic [`C2FS_ID_W-1:0] s_id;
        logic [`C2FS_XID_W-1:0] ox_id;
        logic [`C2FS_XID_W-1:0] rx_id;
        logic [`C2FS_SEQID_W-1:0] seq_id;
        logic [`C2FS_CNT_W-1:0] seq_cnt;
        logic pref;
        logic [`C2FS_LEN_W-1:0] len;
        logic [`C2FS_RSN_W-1:0] reason;
    } c2fs_hdr_t;

    typedef struct packed {
        logic nop;
        logic first;
        logic last;
        logic pref;
        logic [`C2FS_ID_W-1:0] d_id;
        logic [`C2FS_ID_W-1:0] s_id;
        logic [`C2FS_XID_W-1:0] ox_id;
        logic [`C2FS_XID_W-1:0] rx_id;
        logic [`C2FS_SEQID_W-1:0] seq_id;
        logic [`C2FS_LEN_W-1:0] len;
    } c2fs_req_t;

endpackage : c2fs_pkg

// >>> core/c2fs_skid.sv
`timescale 1ns/1ps
`default_nettype none

module c2fs_skid
    import c2fs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    input wire c2fs_hdr_t in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output c2fs_hdr_t out_data_o,
    input wire logic out_ready_i
);

    logic out_vld_r;
    c2fs_hdr_t out_r;
    logic sp_vld_r;
    c2fs_hdr_t sp_r;
    wire logic load_out = !out_vld_r || out_ready_i;
    wire logic push = in_valid_i && !sp_vld_r;

    assign in_ready_o = !sp_vld_r;
    assign out_valid_o = out_vld_r;
    assign out_data_o = out_r;

    // Spare entry catches the word that arrives while the receiver stalls
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_vld_r <= 1'b0;
            out_r <= '0;
            sp_vld_r <= 1'b0;
            sp_r <= '0;
        end else if (load_out) begin
            out_vld_r <= sp_vld_r || push;
            out_r <= sp_vld_r ? sp_r : in_data_i;
            sp_vld_r <= 1'b0;
        end else if (push) begin
            sp_vld_r <= 1'b1;
            sp_r <= in_data_i;
        end
    end

endmodule : c2fs_skid

`default_nettype wire

// >>> core/c2fs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "c2fs_cfg.svh"

module c2fs_top
    import c2fs_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic REQ_VALID_I,
    input wire c2fs_req_t REQ_I,
    output logic REQ_READY_O,
    output logic TX_VALID_O,
    output c2fs_hdr_t TX_HDR_O,
    input wire logic TX_READY_I,
    input wire logic RX_VALID_I,
    input wire c2fs_hdr_t RX_HDR_I,
    input wire logic RX_CRC_OK_I,
    input wire logic RX_BUSY_I,
    output logic RX_READY_O,
    input wire logic RRDY_I,
    output logic RRDY_O,
    input wire logic LOGIN_DONE_I,
    input wire logic [`C2FS_CREDIT_W-1:0] BB_CREDIT_I,
    input wire logic [`C2FS_CREDIT_W-1:0] EE_CREDIT_I,
    input wire logic [`C2FS_LEN_W-1:0] BB_RX_SIZE_I,
    input wire logic [`C2FS_LEN_W-1:0] RX_SIZE_I,
    input wire logic [`C2FS_RETRY_W-1:0] RETRY_MAX_I,
    output logic RX_DELIVER_O,
    output logic RX_SEQ_OPEN_O,
    output logic TX_SEQ_OPEN_O,
    output logic TX_DONE_O,
    output logic TX_FAIL_O,
    output logic OVERSIZE_O
);

    function automatic logic [`C2FS_LEN_W-1:0] min_len(input logic [`C2FS_LEN_W-1:0] a,
                                                        input logic [`C2FS_LEN_W-1:0] b);
        min_len = (a < b) ? a : b;
    endfunction : min_len

    function automatic logic is_class2(input c2fs_sof_t s);
        is_class2 = (s == C2FS_SOF_I2) || (s == C2FS_SOF_N2);
    endfunction : is_class2

    c2fs_state_t state_r;
    c2fs_state_t state_nxt;
    c2fs_hdr_t hdr_r;
    c2fs_hdr_t resp_r;
    c2fs_hdr_t resp_nxt;
    c2fs_hdr_t skid_in;
    logic resp_vld_r;
    logic login_r;
    logic req_ready_r;
    logic rx_ready_r;
    logic rrdy_r;
    logic deliver_r;
    logic rx_open_r;
    logic tx_open_r;
    logic done_r;
    logic fail_r;
    logic oversize_r;
    logic [`C2FS_CNT_W-1:0] seq_cnt_r;
    logic [`C2FS_RETRY_W-1:0] retry_r;
    logic skid_rdy;
    logic bb_avail;
    logic ee_avail;

    // Request side decode
    wire logic req_take = REQ_VALID_I && req_ready_r;
    wire logic [`C2FS_LEN_W-1:0] cap_len = min_len(BB_RX_SIZE_I, RX_SIZE_I);
    wire logic [`C2FS_LEN_W-1:0] req_len = REQ_I.nop ? '0 : REQ_I.len;
    wire logic req_big = req_len > cap_len;
    wire logic new_seq = REQ_I.first || !tx_open_r;
    wire logic [`C2FS_CNT_W-1:0] cnt_next = new_seq ? '0 : `C2FS_CNT_W'(seq_cnt_r + 16'h1);
    wire logic login_rise = LOGIN_DONE_I && !login_r;

    // Receive side decode
    wire logic rx_take = RX_VALID_I && rx_ready_r;
    wire c2fs_kind_t rk = RX_HDR_I.kind;
    wire logic rx_c2 = is_class2(RX_HDR_I.sof);
    wire logic rx_c3 = (RX_HDR_I.sof == C2FS_SOF_I3) || (RX_HDR_I.sof == C2FS_SOF_N3);
    wire logic rx_bad = !rx_c2 && !rx_c3;
    wire logic rx_frame = (rk == C2FS_K_DATA) || (rk == C2FS_K_NOP);
    wire logic rx_answer = rx_take && !rx_c3 && rx_frame && RX_CRC_OK_I;
    wire logic rx_ok = rx_answer && rx_c2 && login_r && !RX_BUSY_I;
    wire logic rx_lc = rx_take && rx_c2 && !rx_frame && RX_CRC_OK_I;
    wire logic rsp_match = rx_lc && (state_r == C2FS_S_WAIT)
                           && (RX_HDR_I.ox_id == hdr_r.ox_id)
                           && (RX_HDR_I.seq_id == hdr_r.seq_id)
                           && (RX_HDR_I.seq_cnt == hdr_r.seq_cnt);
    wire logic rsp_ack = rsp_match && (rk == C2FS_K_ACK);
    wire logic rsp_bsy = rsp_match && ((rk == C2FS_K_PBSY) || (rk == C2FS_K_FBSY));
    wire logic rsp_rjt = rsp_match && ((rk == C2FS_K_PRJT) || (rk == C2FS_K_FRJT));
    wire logic can_retry = retry_r < RETRY_MAX_I;

    // Transmit arbitration; answers to the far end go first
    wire logic push_resp = resp_vld_r && skid_rdy && bb_avail;
    wire logic push_data = (state_r == C2FS_S_PUSH) && !resp_vld_r && skid_rdy
                           && bb_avail && ee_avail && login_r;

    always_comb begin
        resp_nxt = resp_r;
        resp_nxt.d_id = RX_HDR_I.s_id;
        resp_nxt.s_id = RX_HDR_I.d_id;
        resp_nxt.ox_id = RX_HDR_I.ox_id;
        resp_nxt.rx_id = RX_HDR_I.rx_id;
        resp_nxt.seq_id = RX_HDR_I.seq_id;
        resp_nxt.seq_cnt = RX_HDR_I.seq_cnt;
        resp_nxt.pref = RX_HDR_I.pref;
        resp_nxt.len = '0;
        resp_nxt.sof = C2FS_SOF_N2;
        resp_nxt.eof = (RX_HDR_I.eof == C2FS_EOF_T) ? C2FS_EOF_T : C2FS_EOF_N;
        resp_nxt.kind = C2FS_K_ACK;
        resp_nxt.reason = `C2FS_RSN_NONE;
        if (rx_bad) begin
            resp_nxt.kind = C2FS_K_PRJT;
            resp_nxt.eof = C2FS_EOF_N;
            resp_nxt.reason = `C2FS_RSN_DELIM;
        end else if (!login_r) begin
            resp_nxt.kind = C2FS_K_PRJT;
            resp_nxt.eof = C2FS_EOF_N;
            resp_nxt.reason = `C2FS_RSN_NOLOGIN;
        end else if (RX_BUSY_I) begin
            resp_nxt.kind = C2FS_K_PBSY;
            resp_nxt.eof = C2FS_EOF_N;
            resp_nxt.reason = `C2FS_RSN_BUSY;
        end
    end

    assign skid_in = push_resp ? resp_r : hdr_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            C2FS_S_IDLE: begin
                if (req_take && !req_big) begin
                    state_nxt = C2FS_S_PUSH;
                end
            end
            C2FS_S_PUSH: begin
                if (push_data) begin
                    state_nxt = C2FS_S_WAIT;
                end
            end
            C2FS_S_WAIT: begin
                if (rsp_ack || rsp_rjt || (rsp_bsy && !can_retry)) begin
                    state_nxt = C2FS_S_IDLE;
                end else if (rsp_bsy) begin
                    state_nxt = C2FS_S_PUSH;
                end
            end
            default: begin
                state_nxt = C2FS_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_r <= C2FS_S_IDLE;
            req_ready_r <= 1'b0;
            login_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            req_ready_r <= (state_nxt == C2FS_S_IDLE) && !req_take;
            login_r <= LOGIN_DONE_I;
        end
    end

    // Outgoing frame header build
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            hdr_r <= '0;
            seq_cnt_r <= `C2FS_CNT_RST;
            tx_open_r <= 1'b0;
        end else if (req_take && !req_big) begin
            hdr_r.kind <= REQ_I.nop ? C2FS_K_NOP : C2FS_K_DATA;
            hdr_r.sof <= new_seq ? C2FS_SOF_I2 : C2FS_SOF_N2;
            hdr_r.eof <= REQ_I.last ? C2FS_EOF_T : C2FS_EOF_N;
            hdr_r.d_id <= REQ_I.d_id;
            hdr_r.s_id <= REQ_I.s_id;
            hdr_r.ox_id <= REQ_I.ox_id;
            hdr_r.rx_id <= REQ_I.rx_id;
            hdr_r.seq_id <= REQ_I.seq_id;
            hdr_r.seq_cnt <= cnt_next;
            hdr_r.pref <= REQ_I.pref;
            hdr_r.len <= req_len;
            hdr_r.reason <= `C2FS_RSN_NONE;
            seq_cnt_r <= cnt_next;
            tx_open_r <= !REQ_I.last;
        end
    end

    // Answer buffer and receive bookkeeping
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            resp_vld_r <= 1'b0;
            resp_r <= '0;
            rx_ready_r <= 1'b0;
            rrdy_r <= 1'b0;
            deliver_r <= 1'b0;
            rx_open_r <= 1'b0;
        end else begin
            if (rx_answer) begin
                resp_vld_r <= 1'b1;
                resp_r <= resp_nxt;
            end else if (push_resp) begin
                resp_vld_r <= 1'b0;
            end
            rx_ready_r <= !(rx_answer || (resp_vld_r && !push_resp));
            rrdy_r <= rx_take;
            deliver_r <= rx_ok && (rk == C2FS_K_DATA);
            if (rx_ok && (RX_HDR_I.eof == C2FS_EOF_T)) begin
                rx_open_r <= 1'b0;
            end else if (rx_ok && (RX_HDR_I.sof == C2FS_SOF_I2)) begin
                rx_open_r <= 1'b1;
            end
        end
    end

    // Retry count and status pulses
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            retry_r <= `C2FS_RETRY_RST;
            done_r <= 1'b0;
            fail_r <= 1'b0;
            oversize_r <= 1'b0;
        end else begin
            if (req_take) begin
                retry_r <= `C2FS_RETRY_RST;
            end else if (rsp_bsy && can_retry) begin
                retry_r <= retry_r + `C2FS_RETRY_W'(1);
            end
            done_r <= rsp_ack;
            fail_r <= rsp_rjt || (rsp_bsy && !can_retry);
            oversize_r <= req_take && req_big;
        end
    end

    c2fs_credit u_bb_credit (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .load_i(login_rise),
        .init_i(BB_CREDIT_I),
        .take_i(push_resp || push_data),
        .give_i(RRDY_I),
        .avail_o(bb_avail)
    );

    c2fs_credit u_ee_credit (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .load_i(login_rise),
        .init_i(EE_CREDIT_I),
        .take_i(push_data),
        .give_i(rsp_match),
        .avail_o(ee_avail)
    );

    c2fs_skid u_skid (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .in_valid_i(push_resp || push_data),
        .in_data_i(skid_in),
        .in_ready_o(skid_rdy),
        .out_valid_o(TX_VALID_O),
        .out_data_o(TX_HDR_O),
        .out_ready_i(TX_READY_I)
    );

    assign REQ_READY_O = req_ready_r;
    assign RX_READY_O = rx_ready_r;
    assign RRDY_O = rrdy_r;
    assign RX_DELIVER_O = deliver_r;
    assign RX_SEQ_OPEN_O = rx_open_r;
    assign TX_SEQ_OPEN_O = tx_open_r;
    assign TX_DONE_O = done_r;
    assign TX_FAIL_O = fail_r;
    assign OVERSIZE_O = oversize_r;

    sequence s_take_first;
        req_take && !req_big && REQ_I.first;
    endsequence

    sequence s_busy_retry;
        rsp_bsy && can_retry;
    endsequence

    property p_ack_delim;
        @(posedge CLK_I) disable iff (!RST_N_I)
        push_resp && (resp_r.kind == C2FS_K_ACK) |-> resp_r.sof == C2FS_SOF_N2;
    endproperty
    a_ack_delim: assert property (p_ack_delim) else $error("ack start delimiter wrong");

    property p_ack_eof;
        @(posedge CLK_I) disable iff (!RST_N_I)
        rx_ok |=> resp_r.eof == ($past(RX_HDR_I.eof) == C2FS_EOF_T ? C2FS_EOF_T : C2FS_EOF_N);
    endproperty
    a_ack_eof: assert property (p_ack_eof) else $error("ack end delimiter wrong");

    property p_first_sof;
        @(posedge CLK_I) disable iff (!RST_N_I)
        s_take_first |=> hdr_r.sof == C2FS_SOF_I2 && hdr_r.seq_cnt == 16'h0000;
    endproperty
    a_first_sof: assert property (p_first_sof) else $error("first frame delimiter wrong");

    property p_cnt_step;
        @(posedge CLK_I) disable iff (!RST_N_I)
        req_take && !req_big && !new_seq |=>
            hdr_r.seq_cnt == 16'($past(seq_cnt_r) + 16'h1) && hdr_r.sof == C2FS_SOF_N2;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("sequence count not stepped");

    property p_last_eof;
        @(posedge CLK_I) disable iff (!RST_N_I)
        req_take && !req_big |=> (hdr_r.eof == C2FS_EOF_T) == $past(REQ_I.last);
    endproperty
    a_last_eof: assert property (p_last_eof) else $error("end delimiter wrong");

    property p_nop_empty;
        @(posedge CLK_I) disable iff (!RST_N_I)
        push_data && (hdr_r.kind == C2FS_K_NOP) |-> hdr_r.len == '0;
    endproperty
    a_nop_empty: assert property (p_nop_empty) else $error("nop carries data");

    property p_cap;
        @(posedge CLK_I) disable iff (!RST_N_I)
        req_take && req_big |=> OVERSIZE_O && state_r == C2FS_S_IDLE;
    endproperty
    a_cap: assert property (p_cap) else $error("oversize frame accepted");

    property p_ack_all;
        @(posedge CLK_I) disable iff (!RST_N_I)
        rx_ok |=> resp_vld_r && resp_r.kind == C2FS_K_ACK && !RX_READY_O;
    endproperty
    a_ack_all: assert property (p_ack_all) else $error("valid frame not acknowledged");

    property p_busy_ans;
        @(posedge CLK_I) disable iff (!RST_N_I)
        rx_answer && rx_c2 && login_r && RX_BUSY_I |=>
            resp_r.kind == C2FS_K_PBSY && resp_r.reason == `C2FS_RSN_BUSY;
    endproperty
    a_busy_ans: assert property (p_busy_ans) else $error("busy answer missing");

    property p_retry;
        @(posedge CLK_I) disable iff (!RST_N_I)
        s_busy_retry |=> state_r == C2FS_S_PUSH && $stable(hdr_r);
    endproperty
    a_retry: assert property (p_retry) else $error("busied frame not resent");

    property p_c3_drop;
        @(posedge CLK_I) disable iff (!RST_N_I)
        rx_take && rx_c3 |=> RRDY_O && !RX_DELIVER_O ##0 !$rose(resp_vld_r);
    endproperty
    a_c3_drop: assert property (p_c3_drop) else $error("datagram frame not dropped");

    property p_login;
        @(posedge CLK_I) disable iff (!RST_N_I)
        !login_r |-> !((push_resp || push_data)
                       && (skid_in.kind inside {C2FS_K_DATA, C2FS_K_NOP}));
    endproperty
    a_login: assert property (p_login) else $error("frame sent before login");

endmodule : c2fs_top

`default_nettype wire

// >>> test/c2fs_far.sv
`timescale 1ns/1ps
`default_nettype none
`include "c2fs_cfg.svh"

module c2fs_far
    import c2fs_pkg::*;
(
    input wire logic clk_i,
    input wire logic tx_valid_i,
    input wire c2fs_hdr_t tx_hdr_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output c2fs_hdr_t rx_hdr_o,
    input wire logic rx_ready_i,
    output logic rrdy_o,
    input wire logic stall_i,
    input wire logic [1:0] mode_i
);
    c2fs_hdr_t rxq[$];
    c2fs_hdr_t seen[$];
    c2fs_hdr_t a;
    logic give = 1'b0;
    initial begin
        tx_ready_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_hdr_o = '0;
        rrdy_o = 1'b0;
    end
    always @(posedge clk_i) begin
        give = tx_valid_i && tx_ready_o;
        if (rx_valid_o && rx_ready_i) begin
            void'(rxq.pop_front());
        end
        if (give) begin
            seen.push_back(tx_hdr_i);
            a = tx_hdr_i;
            a.d_id = tx_hdr_i.s_id;
            a.s_id = tx_hdr_i.d_id;
            a.sof = C2FS_SOF_N2;
            a.len = '0;
            a.kind = mode_i == 2'h0 ? C2FS_K_ACK : (mode_i == 2'h1 ? C2FS_K_PBSY
                     : (mode_i == 2'h2 ? C2FS_K_FRJT : C2FS_K_FBSY));
            a.eof = (mode_i == 2'h0 && tx_hdr_i.eof == C2FS_EOF_T) ? C2FS_EOF_T : C2FS_EOF_N;
            a.reason = mode_i == 2'h1 ? `C2FS_RSN_BUSY : `C2FS_RSN_NONE;
            if (tx_hdr_i.kind inside {C2FS_K_DATA, C2FS_K_NOP}) begin
                rxq.push_back(a);
            end
        end
    end
    always @(negedge clk_i) begin
        rrdy_o <= give;
        tx_ready_o <= !stall_i;
        rx_valid_o <= rxq.size() > 0;
        // Released bus toggles so stale values never look valid
        rx_hdr_o <= rxq.size() > 0 ? rxq[0] : c2fs_hdr_t'(~rx_hdr_o);
    end
endmodule : c2fs_far

`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "c2fs_cfg.svh"

module tb;
    import c2fs_pkg::*;
    logic clk, rst_n, req_valid, rx_crc_ok, rx_busy, login, stall;
    logic req_ready, tx_valid, tx_ready, rx_valid, rx_ready, rrdy_in, rrdy_out;
    logic done, fail, oversize, deliver, rx_open, tx_open;
    logic [1:0] mode;
    logic [3:0] retry_max;
    logic [31:0] seed, st_seed;
    c2fs_req_t req;
    c2fs_hdr_t tx_hdr, rx_hdr;
    int fails, comparisons, rrdy_seen, open_s, cnt, deliver_seen, rx_open_m;

    c2fs_top c2fs_top_i (.CLK_I(clk), .RST_N_I(rst_n), .REQ_VALID_I(req_valid), .REQ_I(req),
        .REQ_READY_O(req_ready), .TX_VALID_O(tx_valid), .TX_HDR_O(tx_hdr), .TX_READY_I(tx_ready),
        .RX_VALID_I(rx_valid), .RX_HDR_I(rx_hdr), .RX_CRC_OK_I(rx_crc_ok), .RX_BUSY_I(rx_busy),
        .RX_READY_O(rx_ready), .RRDY_I(rrdy_in), .RRDY_O(rrdy_out), .LOGIN_DONE_I(login),
        .BB_CREDIT_I(16'h0002), .EE_CREDIT_I(16'h0002), .BB_RX_SIZE_I(12'h100),
        .RX_SIZE_I(12'h0c0), .RETRY_MAX_I(retry_max), .RX_DELIVER_O(deliver),
        .RX_SEQ_OPEN_O(rx_open), .TX_SEQ_OPEN_O(tx_open), .TX_DONE_O(done), .TX_FAIL_O(fail),
        .OVERSIZE_O(oversize));
    c2fs_far c2fs_far_i (.clk_i(clk), .tx_valid_i(tx_valid), .tx_hdr_i(tx_hdr),
        .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_hdr_o(rx_hdr), .rx_ready_i(rx_ready),
        .rrdy_o(rrdy_in), .stall_i(stall), .mode_i(mode));

    always #50 clk = ~clk;
    always @(negedge clk) begin
        st_seed = lfsr(st_seed);
        stall <= st_seed[0] & st_seed[1];
        if (rrdy_out === 1'b1) rrdy_seen++;
        if (deliver === 1'b1) deliver_seen++;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr

    function automatic c2fs_req_t rnd(input logic f, input logic l, input logic n,
                                      input logic [11:0] len);
        c2fs_req_t r;
        seed = lfsr(seed);
        r = {n, f, l, seed[9], seed[23:0], seed[31:8], seed[15:0], seed[31:16], seed[7:0], len};
        return r;
    endfunction : rnd

    task automatic chk_hdr(input c2fs_hdr_t g, input c2fs_hdr_t e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: header %h, expected %h", $time, g, e);
        end
    endtask : chk_hdr

    task automatic chk_bit(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: flag %b, expected %b", $time, g, e);
        end
    endtask : chk_bit

    // Outcome fin: 0 acknowledged, 1 failed, 2 refused as oversize
    task automatic send(input c2fs_req_t r, input int n_tx, input int fin);
        c2fs_hdr_t e;
        logic d, f, o;
        e = '0;
        if (fin != 2) begin
            if (r.first || open_s == 0) cnt = 0;
            else cnt++;
            open_s = !r.last;
        end
        e.kind = r.nop ? C2FS_K_NOP : C2FS_K_DATA;
        e.sof = cnt == 0 ? C2FS_SOF_I2 : C2FS_SOF_N2;
        e.eof = r.last ? C2FS_EOF_T : C2FS_EOF_N;
        e.d_id = r.d_id;
        e.s_id = r.s_id;
        e.ox_id = r.ox_id;
        e.rx_id = r.rx_id;
        e.seq_id = r.seq_id;
        e.seq_cnt = cnt[15:0];
        e.pref = r.pref;
        e.len = r.nop ? 12'h000 : r.len;
        e.reason = `C2FS_RSN_NONE;
        c2fs_far_i.seen.delete();
        @(negedge clk);
        req_valid = 1'b1;
        req = r;
        while (req_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        {d, f, o} = 3'b000;
        for (int i = 0; i < 400 && !(d | f | o); i++) begin
            {d, f, o} = {done, fail, oversize};
            if (!(d | f | o)) @(negedge clk);
        end
        repeat (3) @(negedge clk);
        chk_bit(d, fin == 0);
        chk_bit(f, fin == 1);
        chk_bit(o, fin == 2);
        chk_bit(tx_open, open_s[0]);
        chk_bit(c2fs_far_i.seen.size() == n_tx, 1'b1);
        foreach (c2fs_far_i.seen[k]) chk_hdr(c2fs_far_i.seen[k], e);
    endtask : send

    task automatic rx(input c2fs_kind_t hk, input c2fs_sof_t s, input c2fs_eof_t t,
                      input logic crc, input logic busy, input int ans, input c2fs_kind_t k,
                      input logic [7:0] rsn);
        c2fs_hdr_t h, e;
        int n0, n1;
        seed = lfsr(seed);
        h = {hk, s, t, seed[23:0], seed[31:8], seed[15:0], seed[31:16], seed[7:0], seed[15:0],
             seed[4], 12'h010, 8'h00};
        e = h;
        e.d_id = h.s_id;
        e.s_id = h.d_id;
        e.kind = k;
        e.sof = C2FS_SOF_N2;
        e.eof = (k == C2FS_K_ACK && t == C2FS_EOF_T) ? C2FS_EOF_T : C2FS_EOF_N;
        e.len = 12'h000;
        e.reason = rsn;
        c2fs_far_i.seen.delete();
        n0 = rrdy_seen;
        n1 = deliver_seen;
        @(negedge clk);
        rx_crc_ok = crc;
        rx_busy = busy;
        c2fs_far_i.rxq.push_back(h);
        repeat (12) @(negedge clk);
        chk_bit(rrdy_seen == n0 + 1, 1'b1);
        chk_bit(c2fs_far_i.seen.size() == ans, 1'b1);
        if (ans > 0) chk_hdr(c2fs_far_i.seen[0], e);
        chk_bit(deliver_seen == n1 + (ans > 0 && k == C2FS_K_ACK && hk == C2FS_K_DATA), 1'b1);
        if (ans > 0 && k == C2FS_K_ACK && (t == C2FS_EOF_T || s == C2FS_SOF_I2))
            rx_open_m = t != C2FS_EOF_T;
        chk_bit(rx_open, rx_open_m[0]);
        rx_busy = 1'b0;
        rx_crc_ok = 1'b1;
    endtask : rx

    task automatic report_and_stop;
        $display("comparisons %0d, fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        report_and_stop();
    end

    initial begin
        {clk, rst_n, req_valid, rx_crc_ok, rx_busy, login, stall} = 7'b0001000;
        {mode, retry_max, req} = '0;
        {seed, st_seed} = {32'h233e, 32'h233e};
        {fails, comparisons, rrdy_seen, open_s, cnt, deliver_seen, rx_open_m} = '0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        login = 1'b1;
        repeat (2) @(negedge clk);
        for (int i = 0; i < 3; i++) send(rnd(i == 0, i == 2, 0, 12'(i * 9)), 1, 0);
        send(rnd(1, 0, 1, 12'h005), 1, 0);
        send(rnd(0, 1, 1, 12'h005), 1, 0);
        send(rnd(1, 1, 0, 12'h0c1), 0, 2);
        send(rnd(1, 1, 0, 12'h0c0), 1, 0);
        $display("transmit tests done");
        mode = 2'h1;
        retry_max = 4'h2;
        send(rnd(1, 1, 0, 12'h008), 3, 1);
        retry_max = 4'h0;
        mode = 2'h3;
        send(rnd(1, 1, 0, 12'h008), 1, 1);
        mode = 2'h2;
        send(rnd(1, 0, 0, 12'h008), 1, 1);
        mode = 2'h0;
        $display("busy and reject tests done");
        rx(C2FS_K_DATA, C2FS_SOF_I2, C2FS_EOF_N, 1, 0, 1, C2FS_K_ACK, `C2FS_RSN_NONE);
        rx(C2FS_K_DATA, C2FS_SOF_N2, C2FS_EOF_T, 1, 0, 1, C2FS_K_ACK, `C2FS_RSN_NONE);
        rx(C2FS_K_NOP, C2FS_SOF_I2, C2FS_EOF_T, 1, 0, 1, C2FS_K_ACK, `C2FS_RSN_NONE);
        rx(C2FS_K_DATA, C2FS_SOF_I2, C2FS_EOF_N, 1, 1, 1, C2FS_K_PBSY, `C2FS_RSN_BUSY);
        rx(C2FS_K_DATA, C2FS_SOF_BAD, C2FS_EOF_N, 1, 0, 1, C2FS_K_PRJT, `C2FS_RSN_DELIM);
        rx(C2FS_K_DATA, C2FS_SOF_I3, C2FS_EOF_T, 1, 0, 0, C2FS_K_ACK, `C2FS_RSN_NONE);
        rx(C2FS_K_DATA, C2FS_SOF_I2, C2FS_EOF_T, 0, 0, 0, C2FS_K_ACK, `C2FS_RSN_NONE);
        login = 1'b0;
        rx(C2FS_K_DATA, C2FS_SOF_I2, C2FS_EOF_N, 1, 0, 1, C2FS_K_PRJT, `C2FS_RSN_NOLOGIN);
        login = 1'b1;
        $display("receive tests done");
        report_and_stop();
    end
endmodule : tb

`default_nettype wire
